// *** rtl/usl_top.sv ***
// serial line controller with ahb-lite registers, queues, loop-back and infrared coding
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "usl_map.svh"
module usl_top #(
  parameter int DEPTH = 16,
  parameter int AW = 12
) (
  // clock, enable, reset
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic sys_rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [AW-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // serial and modem pins
  input wire logic serial_in_pin_i,
  input wire logic ring_indicate_n_i,
  output logic serial_out_pin_o,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic baud16_o
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  // -------------------------------------------------------------
  // helper functions
  // -------------------------------------------------------------
  // register selection from index and line control
  function automatic usl_pkg::usl_reg_e reg_sel(input logic [2:0] idx, input logic [7:0] line_control_reg);
    usl_pkg::usl_reg_e r;
    r = usl_pkg::USL_R_SPR;
    if (line_control_reg[`USL_LCR_DLAB] && idx == `USL_IDX_DATA) r = usl_pkg::USL_R_DLL;
    else if (line_control_reg[`USL_LCR_DLAB] && idx == `USL_IDX_IER) r = usl_pkg::USL_R_DLM;
    else if (line_control_reg == `USL_LCR_ENH && idx == `USL_IDX_IQ) r = usl_pkg::USL_R_EFR;
    else if (line_control_reg == `USL_LCR_ENH && idx[2]) r = usl_pkg::USL_R_XO;
    else if (idx == `USL_IDX_DATA) r = usl_pkg::USL_R_DATA;
    else if (idx == `USL_IDX_IER) r = usl_pkg::USL_R_IER;
    else if (idx == `USL_IDX_IQ) r = usl_pkg::USL_R_IQ;
    else if (idx == `USL_IDX_LCR) r = usl_pkg::USL_R_LCR;
    else if (idx == `USL_IDX_MCR) r = usl_pkg::USL_R_MCR;
    else if (idx == `USL_IDX_LSR) r = usl_pkg::USL_R_LSR;
    else if (idx == `USL_IDX_MSR) r = usl_pkg::USL_R_MSR;
    return r;
  endfunction : reg_sel

  // parity bit for a character of lm1+1 bits
  function automatic logic par_bit(input logic [7:0] d, input logic [2:0] lm1, input logic ev);
    logic [7:0] m;
    m = 8'hff >> (3'h7 - lm1);
    return (^(d & m)) ^ ~ev;
  endfunction : par_bit

  // level table 1, 4, 8, 14, 14
  function automatic logic [4:0] trig_lvl(input logic [2:0] k);
    logic [4:0] v;
    v = `USL_TRIG3;
    if (k == 3'h0) v = `USL_TRIG0;
    else if (k == 3'h1) v = `USL_TRIG1;
    else if (k == 3'h2) v = `USL_TRIG2;
    return v;
  endfunction : trig_lvl

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // -------------------------------------------------------------
  // ahb-lite slave, one wait state per transfer
  // -------------------------------------------------------------
  logic [7:0] lcr_q, mcr_q, ier_q, fcr_q, efr_q, spr_q;
  usl_pkg::usl_req_s req_q;
  logic pend_q;
  logic acc;
  logic wr_ev;
  logic rd_ev;
  logic [7:0] wd;
  logic [7:0] rd_val;
  usl_pkg::usl_reg_e sel;
  assign acc = hsel_i && htrans_i[1] && hready_i;
  assign sel = reg_sel(req_q.idx, lcr_q);
  assign wr_ev = ce_i && pend_q && req_q.wr && req_q.map;
  assign rd_ev = ce_i && pend_q && !req_q.wr && req_q.map;
  assign wd = hwdata_i[7:0];

  // address capture and ready
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pend_q <= 1'b0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      req_q <= '0;
    end
    else if (ce_i)
    begin
      if (pend_q)
      begin
        pend_q <= 1'b0;
        hreadyout_o <= 1'b1;
      end
      else if (acc)
      begin
        pend_q <= 1'b1;
        hreadyout_o <= 1'b0;
        req_q.wr <= hwrite_i;
        req_q.idx <= haddr_i[4:2];
        req_q.map <= (haddr_i[AW-1:5] == '0) && (haddr_i[1:0] == 2'h0) && (hsize_i == 3'h2);
      end
    end
  end

  // read data, zero for writes and unmapped words
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i) hrdata_o <= 32'h0;
    else if (ce_i && pend_q) hrdata_o <= {24'h0, rd_ev ? rd_val : 8'h00};
  end

  a_bus_wait: assert property (ce_i && acc && !pend_q |=> !hreadyout_o)
    else $error("no wait state");

  // -------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------
  logic [7:0] xo_q [4];
  logic [15:0] div_q;
  logic txr;
  logic rxr;
  assign txr = wr_ev && sel == usl_pkg::USL_R_IQ && wd[`USL_FCR_TXR];
  assign rxr = wr_ev && sel == usl_pkg::USL_R_IQ && wd[`USL_FCR_RXR];

  // register writes; enhanced group cleared by reset
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lcr_q <= `USL_REG_RST;
      mcr_q <= `USL_REG_RST;
      ier_q <= `USL_REG_RST;
      fcr_q <= `USL_REG_RST;
      efr_q <= `USL_REG_RST;
      spr_q <= `USL_REG_RST;
      div_q <= `USL_DIV_RST;
      for (int i = 0; i < 4; i++) xo_q[i] <= `USL_REG_RST;
    end
    else if (wr_ev)
    begin
      case (sel)
        usl_pkg::USL_R_DLL: div_q[7:0] <= wd;
        usl_pkg::USL_R_DLM: div_q[15:8] <= wd;
        usl_pkg::USL_R_IER: ier_q <= wd;
        usl_pkg::USL_R_IQ: fcr_q <= wd & 8'hf9;
        usl_pkg::USL_R_EFR: efr_q <= wd;
        usl_pkg::USL_R_LCR: lcr_q <= wd;
        usl_pkg::USL_R_MCR: mcr_q <= wd;
        usl_pkg::USL_R_SPR: spr_q <= wd;
        usl_pkg::USL_R_XO: xo_q[req_q.idx[1:0]] <= wd;
        default: ;
      endcase
    end
  end

  a_enh_reset: assert property ($past(sys_rst_i) |-> efr_q == 8'h00)
    else $error("efr not cleared");

  // -------------------------------------------------------------
  // rate generator, sixteen ticks per bit
  // -------------------------------------------------------------
  logic [15:0] bcnt_q;
  logic [1:0] pre_q;
  logic bhit;
  logic tick;
  assign bhit = bcnt_q >= ((div_q == 16'h0) ? 16'h0 : div_q - 16'h1);
  assign tick = ce_i && bhit && (!mcr_q[`USL_MCR_PRE] || pre_q == 2'h3);

  // divisor and prescale counters
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bcnt_q <= 16'h0;
      pre_q <= 2'h0;
      baud16_o <= 1'b0;
    end
    else if (ce_i)
    begin
      bcnt_q <= bhit ? 16'h0 : bcnt_q + 16'h1;
      if (bhit) pre_q <= pre_q + 2'h1;
      baud16_o <= tick;
    end
  end

  // -------------------------------------------------------------
  // queues
  // -------------------------------------------------------------
  logic [7:0] txm [DEPTH];
  logic [7:0] rxm [DEPTH];
  logic [PW-1:0] twp_q, trp_q, rwp_q, rrp_q;
  logic [CW-1:0] tcnt_q, rcnt_q, lim;
  logic tpush, tpop, rpush, rpop, rfull;
  logic [7:0] rdat;
  assign lim = fcr_q[`USL_FCR_EN] ? FULL : CW'(1);
  assign tpush = wr_ev && sel == usl_pkg::USL_R_DATA && tcnt_q < lim;
  assign rpop = rd_ev && sel == usl_pkg::USL_R_DATA && rcnt_q != '0;
  assign rfull = rcnt_q >= lim;

  // queue storage
  always_ff @(posedge clk_i)
  begin
    if (tpush) txm[twp_q] <= wd;
    if (rpush && !rfull) rxm[rwp_q] <= rdat;
  end

  // transmit pointers and count
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      twp_q <= '0;
      trp_q <= '0;
      tcnt_q <= '0;
    end
    else if (txr)
    begin
      twp_q <= '0;
      trp_q <= '0;
      tcnt_q <= '0;
    end
    else if (ce_i)
    begin
      if (tpush) twp_q <= PW'(twp_q + 1'b1);
      if (tpop) trp_q <= PW'(trp_q + 1'b1);
      tcnt_q <= tcnt_q + CW'(tpush) - CW'(tpop);
    end
  end

  // receive pointers and count
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rwp_q <= '0;
      rrp_q <= '0;
      rcnt_q <= '0;
    end
    else if (rxr)
    begin
      rwp_q <= '0;
      rrp_q <= '0;
      rcnt_q <= '0;
    end
    else if (ce_i)
    begin
      if (rpush && !rfull) rwp_q <= PW'(rwp_q + 1'b1);
      if (rpop) rrp_q <= PW'(rrp_q + 1'b1);
      rcnt_q <= rcnt_q + CW'(rpush && !rfull) - CW'(rpop);
    end
  end

  a_queue_bound: assert property (tcnt_q <= FULL && rcnt_q <= FULL)
    else $error("queue overfilled");

  // -------------------------------------------------------------
  // transmitter
  // -------------------------------------------------------------
  usl_pkg::usl_st_e tst_q;
  logic [3:0] tt_q;
  logic [2:0] tb_q, lm1;
  logic [7:0] tsh_q;
  logic tpar_q, tline_q;
  assign lm1 = 3'(lcr_q[1:0]) + 3'h4;
  assign tpop = tick && tst_q == usl_pkg::USL_S_IDLE && tcnt_q != '0;

  // character framing and shifting
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tst_q <= usl_pkg::USL_S_IDLE;
      tt_q <= 4'h0;
      tb_q <= 3'h0;
      tsh_q <= 8'h00;
      tpar_q <= 1'b0;
      tline_q <= 1'b1;
    end
    else if (tick)
    begin
      tt_q <= tt_q + 4'h1;
      case (tst_q)
        usl_pkg::USL_S_IDLE:
          if (tcnt_q != '0)
          begin
            tsh_q <= txm[trp_q];
            tpar_q <= par_bit(txm[trp_q], lm1, lcr_q[`USL_LCR_EPS]);
            tline_q <= 1'b0;
            tt_q <= 4'h0;
            tst_q <= usl_pkg::USL_S_START;
          end
        usl_pkg::USL_S_START:
          if (tt_q == `USL_OVS)
          begin
            tline_q <= tsh_q[0];
            tsh_q <= tsh_q >> 1;
            tb_q <= 3'h0;
            tst_q <= usl_pkg::USL_S_DATA;
          end
        usl_pkg::USL_S_DATA:
          if (tt_q == `USL_OVS)
          begin
            tb_q <= tb_q + 3'h1;
            tline_q <= tsh_q[0];
            tsh_q <= tsh_q >> 1;
            if (tb_q == lm1)
            begin
              tline_q <= lcr_q[`USL_LCR_PEN] ? tpar_q : 1'b1;
              tb_q <= 3'h0;
              tst_q <= lcr_q[`USL_LCR_PEN] ? usl_pkg::USL_S_PAR : usl_pkg::USL_S_STOP;
            end
          end
        usl_pkg::USL_S_PAR:
          if (tt_q == `USL_OVS)
          begin
            tline_q <= 1'b1;
            tst_q <= usl_pkg::USL_S_STOP;
          end
        default:
          if (tt_q == `USL_OVS)
          begin
            tb_q <= 3'h1;
            if (!lcr_q[`USL_LCR_STB] || tb_q != 3'h0) tst_q <= usl_pkg::USL_S_IDLE;
          end
      endcase
    end
  end

  // -------------------------------------------------------------
  // serial output and modem outputs
  // -------------------------------------------------------------
  logic irda, loop, arts_q;
  assign irda = mcr_q[`USL_MCR_IRDA];
  assign loop = mcr_q[`USL_MCR_LOOP];

  // line coding of the output pin
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i) serial_out_pin_o <= 1'b1;
    else if (ce_i)
    begin
      if (loop) serial_out_pin_o <= !irda;
      else if (irda) serial_out_pin_o <= !tline_q && tt_q < `USL_IR_W;
      else serial_out_pin_o <= tline_q;
    end
  end

  // automatic request-to-send hysteresis
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i) arts_q <= 1'b0;
    else if (ce_i)
    begin
      if (!efr_q[`USL_EFR_ARTS]) arts_q <= 1'b0;
      else if (5'(rcnt_q) >= trig_lvl(3'(fcr_q[7:6]) + 3'h1)) arts_q <= 1'b1;
      else if (fcr_q[7:6] == 2'h0 ? rcnt_q == '0 :
               5'(rcnt_q) <= trig_lvl(3'(fcr_q[7:6]) - 3'h1)) arts_q <= 1'b0;
    end
  end

  // modem control pins, inactive high after reset
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      rts_n_o <= !mcr_q[`USL_MCR_RTS] || (arts_q && efr_q[`USL_EFR_ARTS]);
      dtr_n_o <= !mcr_q[`USL_MCR_DTR];
    end
  end

  a_rts_reset: assert property ($past(sys_rst_i) |-> rts_n_o)
    else $error("rts low at reset");
  a_rts_plain: assert property (ce_i && !efr_q[`USL_EFR_ARTS]
    |=> rts_n_o == !$past(mcr_q[`USL_MCR_RTS]))
    else $error("rts wrong");
  a_plain_idle: assert property (ce_i && !irda && !loop && tst_q == usl_pkg::USL_S_IDLE
    |=> serial_out_pin_o)
    else $error("idle low");
  a_ir_rest: assert property (ce_i && irda && (loop || tline_q)
    |=> !serial_out_pin_o)
    else $error("ir not low");
  a_loop_out: assert property (ce_i && loop && !irda
    |=> serial_out_pin_o[*1])
    else $error("pin active in loop");

  // -------------------------------------------------------------
  // receiver
  // -------------------------------------------------------------
  logic rs1_q, rs2_q, ri1_q, ri2_q, rip_q, rxp_q, rline, rpe_q;
  logic [3:0] irh_q, rt_q;
  logic [2:0] rb_q;
  logic [7:0] rsh_q;
  usl_pkg::usl_st_e rst_q;
  assign rline = loop ? tline_q : irda ? !(rs2_q || irh_q != 4'h0) : rs2_q;
  assign rdat = rsh_q >> (3'h7 - lm1);
  assign rpush = tick && rst_q == usl_pkg::USL_S_STOP && rt_q == `USL_OVS;

  // pin synchronisers and infrared pulse stretch
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rs1_q <= 1'b1;
      rs2_q <= 1'b1;
      ri1_q <= 1'b1;
      ri2_q <= 1'b1;
      rip_q <= 1'b1;
      irh_q <= 4'h0;
    end
    else if (ce_i)
    begin
      rs1_q <= serial_in_pin_i;
      rs2_q <= rs1_q;
      ri1_q <= ring_indicate_n_i;
      ri2_q <= ri1_q;
      rip_q <= ri2_q;
      if (irda && rs2_q) irh_q <= `USL_OVS;
      else if (tick && irh_q != 4'h0) irh_q <= irh_q - 4'h1;
    end
  end

  // start detection and centre sampling
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rst_q <= usl_pkg::USL_S_IDLE;
      rt_q <= 4'h0;
      rb_q <= 3'h0;
      rsh_q <= 8'h00;
      rpe_q <= 1'b0;
      rxp_q <= 1'b1;
    end
    else if (tick)
    begin
      rxp_q <= rline;
      rt_q <= rt_q + 4'h1;
      case (rst_q)
        usl_pkg::USL_S_IDLE:
          if (rxp_q && !rline)
          begin
            rt_q <= 4'h0;
            rpe_q <= 1'b0;
            rst_q <= usl_pkg::USL_S_START;
          end
        usl_pkg::USL_S_START:
          if (rt_q == `USL_MID)
          begin
            rt_q <= 4'h0;
            rb_q <= 3'h0;
            rst_q <= rline ? usl_pkg::USL_S_IDLE : usl_pkg::USL_S_DATA;
          end
        usl_pkg::USL_S_DATA:
          if (rt_q == `USL_OVS)
          begin
            rsh_q <= {rline, rsh_q[7:1]};
            rb_q <= rb_q + 3'h1;
            if (rb_q == lm1)
              rst_q <= lcr_q[`USL_LCR_PEN] ? usl_pkg::USL_S_PAR : usl_pkg::USL_S_STOP;
          end
        usl_pkg::USL_S_PAR:
          if (rt_q == `USL_OVS)
          begin
            rpe_q <= rline != par_bit(rdat, lm1, lcr_q[`USL_LCR_EPS]);
            rst_q <= usl_pkg::USL_S_STOP;
          end
        default:
          if (rt_q == `USL_OVS) rst_q <= usl_pkg::USL_S_IDLE;
      endcase
    end
  end

  a_loop_route: assert property (tick && loop |=> rxp_q == $past(tline_q))
    else $error("loop not routed");

  // -------------------------------------------------------------
  // status flags and read mux
  // -------------------------------------------------------------
  logic oe_q, pe_q, fe_q, teri_q, lsr_rd, msr_rd;
  logic [7:0] lsr, msr, isr;
  assign lsr_rd = rd_ev && sel == usl_pkg::USL_R_LSR;
  assign msr_rd = rd_ev && sel == usl_pkg::USL_R_MSR;

  // sticky flags, a new event wins over the read that clears
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      oe_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      teri_q <= 1'b0;
    end
    else if (ce_i)
    begin
      oe_q <= (rpush && rfull) || (oe_q && !lsr_rd);
      pe_q <= (rpush && rpe_q) || (pe_q && !lsr_rd);
      fe_q <= (rpush && !rline) || (fe_q && !lsr_rd);
      teri_q <= (ri2_q && !rip_q) || (teri_q && !msr_rd);
    end
  end

  a_ri_flag: assert property (ce_i && ri2_q && !rip_q |=> teri_q)
    else $error("ring edge lost");

  // status words and priority code
  always_comb
  begin
    lsr = {1'b0, tcnt_q == '0 && tst_q == usl_pkg::USL_S_IDLE, tcnt_q == '0, 1'b0,
           fe_q, pe_q, oe_q, rcnt_q != '0};
    msr = {1'b0, !ri2_q, 3'h0, teri_q, 2'h0};
    isr = 8'h01;
    if (ier_q[2] && (oe_q || pe_q || fe_q)) isr = 8'h06;
    else if (ier_q[0] && 5'(rcnt_q) >= trig_lvl(3'(fcr_q[7:6]))) isr = 8'h04;
    else if (ier_q[1] && tcnt_q == '0) isr = 8'h02;
    else if (ier_q[3] && teri_q) isr = 8'h00;
    if (fcr_q[`USL_FCR_EN]) isr = isr | 8'hc0;
  end

  // register read selection
  always_comb
  begin
    case (sel)
      usl_pkg::USL_R_DATA: rd_val = rxm[rrp_q];
      usl_pkg::USL_R_DLL: rd_val = div_q[7:0];
      usl_pkg::USL_R_DLM: rd_val = div_q[15:8];
      usl_pkg::USL_R_IER: rd_val = ier_q;
      usl_pkg::USL_R_IQ: rd_val = isr;
      usl_pkg::USL_R_EFR: rd_val = efr_q;
      usl_pkg::USL_R_LCR: rd_val = lcr_q;
      usl_pkg::USL_R_MCR: rd_val = mcr_q;
      usl_pkg::USL_R_LSR: rd_val = lsr;
      usl_pkg::USL_R_MSR: rd_val = msr;
      usl_pkg::USL_R_XO: rd_val = xo_q[req_q.idx[1:0]];
      default: rd_val = spr_q;
    endcase
  end

  c_loop_rx: cover property (loop && rpush);
  c_ir_tx: cover property (irda && serial_out_pin_o);
  c_ring: cover property (teri_q && msr_rd);
  c_auto_rts: cover property (arts_q && rts_n_o);
endmodule : usl_top

// *** rtl/usl_map.svh ***
// register indices, field positions, reset values and timing counts of the serial block
`ifndef USL_MAP_SVH
`define USL_MAP_SVH
// register index; byte address is four times the index
`define USL_IDX_DATA 3'h0
`define USL_IDX_IER 3'h1
`define USL_IDX_IQ 3'h2
`define USL_IDX_LCR 3'h3
`define USL_IDX_MCR 3'h4
`define USL_IDX_LSR 3'h5
`define USL_IDX_MSR 3'h6
`define USL_IDX_SPR 3'h7
// line control value that opens the enhanced group
`define USL_LCR_ENH 8'hbf
// field positions
`define USL_LCR_STB 2
`define USL_LCR_PEN 3
`define USL_LCR_EPS 4
`define USL_LCR_DLAB 7
`define USL_MCR_DTR 0
`define USL_MCR_RTS 1
`define USL_MCR_LOOP 4
`define USL_MCR_IRDA 6
`define USL_MCR_PRE 7
`define USL_EFR_ARTS 6
`define USL_FCR_EN 0
`define USL_FCR_RXR 1
`define USL_FCR_TXR 2
// reset values
`define USL_REG_RST 8'h00
`define USL_DIV_RST 16'h0001
// trigger levels in characters
`define USL_TRIG0 5'h01
`define USL_TRIG1 5'h04
`define USL_TRIG2 5'h08
`define USL_TRIG3 5'h0e
// sixteen ticks per bit, centre tick and infrared pulse width in ticks
`define USL_OVS 4'hf
`define USL_MID 4'h7
`define USL_IR_W 4'h3
`endif

// *** rtl/usl_pkg.sv ***
// types shared by the serial line block
package usl_pkg;
  typedef enum logic [3:0] {
    USL_R_DATA, USL_R_DLL, USL_R_DLM, USL_R_IER, USL_R_IQ, USL_R_EFR,
    USL_R_LCR, USL_R_MCR, USL_R_LSR, USL_R_MSR, USL_R_SPR, USL_R_XO
  } usl_reg_e;
  typedef enum logic [2:0] {
    USL_S_IDLE, USL_S_START, USL_S_DATA, USL_S_PAR, USL_S_STOP
  } usl_st_e;
  typedef struct packed {
    logic wr;
    logic map;
    logic [2:0] idx;
  } usl_req_s;
endpackage : usl_pkg

// *** testbench/usl_far.sv ***
// far-end serial sender model for the serial line block
`timescale 1ns/1ps
module usl_far (
  // clock and line format
  input wire logic clk_i,
  input wire logic ir_i,
  // serial line toward the block
  output logic line_o
);
  logic busy = 1'b0;
  logic bit_q = 1'b1;
  // ---------------------------------
  // line level: idle level of the format outside frames
  // ---------------------------------
  assign line_o = busy ? bit_q : !ir_i;
  // start, eight data bits lsb first, even parity, stop; bad flips parity
  task send(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^b ^ bad, b, 1'b0};
    @(posedge clk_i);
    busy <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      bit_q <= f[i];
      repeat (16) @(posedge clk_i);
    end
    busy <= 1'b0;
  endtask : send
endmodule : usl_far

// *** testbench/usl_top_bench.sv ***
// self-checking bench for the serial line block
`timescale 1ns/1ps
module usl_top_bench;
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e;} usl_row_s;
  logic clk_i, ce_i, sys_rst_i, hsel, hwrite, hready, hresp;
  logic ring_n, sin, sout, rts_n, dtr_n, b16, ir;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  int errors, tests_run, pulses;
  usl_row_s rows [11];
  usl_top DUT (.clk_i(clk_i), .ce_i(ce_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .serial_in_pin_i(sin), .ring_indicate_n_i(ring_n),
    .serial_out_pin_o(sout), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .baud16_o(b16));
  usl_far FAR (.clk_i(clk_i), .ir_i(ir), .line_o(sin));
  // ---------------------------------
  // helpers
  // ---------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // waits for an edge that samples hready high
  task wait_rdy;
    @(posedge clk_i);
    while (hready !== 1'b1)
      @(posedge clk_i);
  endtask : wait_rdy
  // one ahb-lite single word transfer; read data lands in rd
  task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task summarize;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // clock and watchdog
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial
  begin
    #200000;
    errors++;
    summarize();
  end
  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial
  begin
    errors = 0;
    tests_run = 0;
    {ce_i, sys_rst_i, ring_n, ir, hsel, hwrite} = 6'b111000;
    haddr = 12'h000;
    htrans = 2'h0;
    hwdata = 32'h0;
    rows = '{{1'b0, 12'h010, 8'h00, 8'h00}, {1'b1, 12'h01c, 8'h5a, 8'h5a},
      {1'b1, 12'h00c, 8'h80, 8'h80}, {1'b1, 12'h000, 8'h01, 8'h01},
      {1'b1, 12'h004, 8'h00, 8'h00}, {1'b1, 12'h00c, 8'hbf, 8'hbf},
      {1'b0, 12'h008, 8'h00, 8'h00}, {1'b1, 12'h010, 8'h11, 8'h11},
      {1'b1, 12'h00c, 8'h03, 8'h03}, {1'b0, 12'h010, 8'h00, 8'h00},
      {1'b1, 12'h020, 8'hff, 8'h00}};
    repeat (10) @(posedge clk_i);
    chk(32'(rts_n), 32'h1);
    chk(32'(sout), 32'h1);
    sys_rst_i <= 1'b0;
    // register table: reset values, divisor latch, enhanced group, unmapped
    foreach (rows[i])
    begin
      if (rows[i].w)
        bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 8'h00);
      chk(rd, {24'h0, rows[i].e});
    end
    // request-to-send under host control
    bus(1'b1, 12'h010, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(32'(rts_n), 32'h0);
    bus(1'b1, 12'h010, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(32'(rts_n), 32'h1);
    // infrared format rests low
    bus(1'b1, 12'h010, 8'h40);
    ir <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(32'(sout), 32'h0);
    ir <= 1'b0;
    bus(1'b1, 12'h010, 8'h00);
    // the format switch decodes a false frame: let it end, clear its flags, flush it
    repeat (200) @(posedge clk_i);
    bus(1'b0, 12'h014, 8'h00);
    // loop-back with even parity: pin stays idle, character returns
    bus(1'b1, 12'h008, 8'h03);
    bus(1'b1, 12'h00c, 8'h1b);
    bus(1'b1, 12'h010, 8'h10);
    bus(1'b1, 12'h000, 8'ha7);
    for (int i = 0; i < 250; i++)
    begin
      @(posedge clk_i);
      chk(32'(sout), 32'h1);
    end
    bus(1'b0, 12'h014, 8'h00);
    chk(rd & 32'h0d, 32'h01);
    bus(1'b0, 12'h000, 8'h00);
    chk(rd, 32'ha7);
    // external frame with a wrong parity bit
    bus(1'b1, 12'h010, 8'h00);
    FAR.send(8'h35, 1'b1);
    repeat (40) @(posedge clk_i);
    bus(1'b0, 12'h014, 8'h00);
    chk(rd & 32'h04, 32'h04);
    bus(1'b0, 12'h000, 8'h00);
    chk(rd, 32'h35);
    // ring input trailing edge, flag cleared by reading
    ring_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    ring_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    bus(1'b0, 12'h018, 8'h00);
    chk(rd & 32'h04, 32'h04);
    bus(1'b0, 12'h018, 8'h00);
    chk(rd & 32'h04, 32'h00);
    // rate generator: divisor three, then prescale by four
    bus(1'b1, 12'h00c, 8'h80);
    bus(1'b1, 12'h000, 8'h03);
    bus(1'b1, 12'h00c, 8'h03);
    pulses = 0;
    repeat (30)
    begin
      @(posedge clk_i);
      pulses += int'(b16);
    end
    chk(pulses, 32'd10);
    bus(1'b1, 12'h010, 8'h80);
    repeat (4) @(posedge clk_i);
    pulses = 0;
    repeat (36)
    begin
      @(posedge clk_i);
      pulses += int'(b16);
    end
    chk(pulses, 32'd3);
    // mid-run reset: modem outputs, enhanced group and bus response back at rest
    bus(1'b1, 12'h010, 8'h03);
    bus(1'b1, 12'h00c, 8'hbf);
    bus(1'b1, 12'h008, 8'h40);
    repeat (2) @(posedge clk_i);
    chk(32'(dtr_n), 32'h0);
    chk(32'(rts_n), 32'h0);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({29'h0, rts_n, dtr_n, sout}, 32'h7);
    chk(32'(hresp), 32'h0);
    sys_rst_i <= 1'b0;
    bus(1'b1, 12'h00c, 8'hbf);
    bus(1'b0, 12'h008, 8'h00);
    chk(rd, 32'h0);
    summarize();
  end
endmodule : usl_top_bench
